// >>> design/boot_select_decode.v
// decode of latched strap bits and fused print control into boot selection
`timescale 1ns/1ps
`include "strap_boot_regs.vh"

module boot_select_decode (
  input wire [`STRAP_W-1:0] strap_bits,
  input wire [1:0] print_ctrl,
  output reg boot_flash,
  output reg boot_download,
  output reg print_en,
  output reg strap_invalid
);

  always @* begin
    boot_flash = strap_bits[`STRAP_A] & strap_bits[`STRAP_C];
    boot_download = strap_bits[`STRAP_A] & strap_bits[`STRAP_B] & ~strap_bits[`STRAP_C];
    // far side must never strap b and c both low; flagged, not corrected
    strap_invalid = ~strap_bits[`STRAP_B] & ~strap_bits[`STRAP_C];
    case (print_ctrl)
      `PRINT_ALWAYS_ON: print_en = 1'b1;
      `PRINT_ON_WHEN_LOW: print_en = ~strap_bits[`STRAP_B];
      `PRINT_ON_WHEN_HIGH: print_en = strap_bits[`STRAP_B];
      default: print_en = 1'b0;
    endcase
  end

endmodule

// >>> design/strap_boot_regs.vh
// register map, field layout, reset values and timing for the strap latch and boot select
`ifndef STRAP_BOOT_REGS_VH
`define STRAP_BOOT_REGS_VH

// ****************************************
// bus geometry
// ****************************************
`define ADDR_W 12
`define DATA_W 32
`define DATA_ZERO 32'h00000000
`define STRAP_W 3

// ****************************************
// register byte addresses
// ****************************************
`define OFS_STRAP_STATUS 12'h000
`define OFS_BOOT_STATUS 12'h004
`define OFS_PIN_OUT 12'h008
`define OFS_PIN_OE 12'h00C
`define OFS_PIN_IN 12'h010
`define OFS_PRINT_CTRL 12'h014

// ****************************************
// strap bit positions
// ****************************************
`define STRAP_A 0
`define STRAP_B 1
`define STRAP_C 2

// ****************************************
// boot status fields
// ****************************************
`define BOOT_FLASH_BIT 0
`define BOOT_DOWNLOAD_BIT 1
`define BOOT_PRINT_BIT 2
`define BOOT_INVALID_BIT 3
`define BOOT_IN_RESET_BIT 4

// ****************************************
// fused print control codes
// ****************************************
`define PRINT_ALWAYS_ON 2'h0
`define PRINT_ON_WHEN_LOW 2'h1
`define PRINT_ON_WHEN_HIGH 2'h2
`define PRINT_ALWAYS_OFF 2'h3

// ****************************************
// reset values
// ****************************************
`define STRAP_RESET 3'h7
`define PIN_OUT_RESET 3'h0
`define PIN_OE_RESET 3'h0

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 10
`define STRAP_HOLD_US 3000
`define HOLD_CNT_W 16

`endif

// >>> design/strap_pin_latch_boot_select.v
// strap pin latch with boot-mode decode, pin hand-back and apb status registers
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "strap_boot_regs.vh"

module strap_pin_latch_boot_select #(
  parameter HOLD_CYCLES = `STRAP_HOLD_US * `CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [`DATA_W-1:0] pwdata,
  output wire [`DATA_W-1:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire chip_en,
  input wire por_rst,
  input wire wdt_rst,
  input wire brownout_rst,
  input wire super_wdt_rst,
  input wire glitch_rst,
  input wire [1:0] print_ctrl_fuse,
  input wire strap_pin_a_in,
  output wire strap_pin_a_out,
  output wire strap_pin_a_oe,
  input wire strap_pin_b_in,
  output wire strap_pin_b_out,
  output wire strap_pin_b_oe,
  input wire strap_pin_c_in,
  output wire strap_pin_c_out,
  output wire strap_pin_c_oe,
  output wire strap_pin_c_pullup,
  output wire sys_reset_active,
  output wire boot_flash,
  output wire boot_download,
  output wire print_en,
  output wire strap_invalid
);

  localparam [`HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CYCLES[`HOLD_CNT_W-1:0] - 1'b1;

  // ****************************************
  // system reset tracking
  // ****************************************
  wire reset_source;
  reg sys_rst_reg;
  reg sys_rst_next;
  reg [`HOLD_CNT_W-1:0] hold_cnt_reg;
  reg [`HOLD_CNT_W-1:0] hold_cnt_next;

  // a low chip enable is treated as power-down, so the straps are taken afresh
  assign reset_source = por_rst | wdt_rst | brownout_rst | super_wdt_rst
                        | glitch_rst | ~chip_en;

  always @* begin
    sys_rst_next = sys_rst_reg;
    hold_cnt_next = hold_cnt_reg;
    if (reset_source) begin
      sys_rst_next = 1'b1;
      hold_cnt_next = {`HOLD_CNT_W{1'b0}};
    end else if (sys_rst_reg) begin
      // pins must stay steady for the hold time after enable rises
      if (hold_cnt_reg == HOLD_LAST) begin
        sys_rst_next = 1'b0;
      end else begin
        hold_cnt_next = hold_cnt_reg + 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_rst_reg <= 1'b1;
      hold_cnt_reg <= {`HOLD_CNT_W{1'b0}};
    end else begin
      sys_rst_reg <= sys_rst_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // ****************************************
  // strap sampling and decode
  // ****************************************
  wire [`STRAP_W-1:0] pin_level;
  wire [`STRAP_W-1:0] strap_bits;
  wire dec_flash;
  wire dec_download;
  wire dec_print;
  wire dec_invalid;

  assign pin_level = {strap_pin_c_in, strap_pin_b_in, strap_pin_a_in};

  // sampling stops the cycle the reset ends, later pin activity is not seen
  strap_sampler u_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .sample_en(sys_rst_reg),
    .pin_level(pin_level),
    .strap_bits(strap_bits)
  );

  boot_select_decode u_decode (
    .strap_bits(strap_bits),
    .print_ctrl(print_ctrl_fuse),
    .boot_flash(dec_flash),
    .boot_download(dec_download),
    .print_en(dec_print),
    .strap_invalid(dec_invalid)
  );

  reg flash_reg;
  reg download_reg;
  reg print_reg;
  reg invalid_reg;
  reg in_reset_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reg <= 1'b0;
      download_reg <= 1'b0;
      print_reg <= 1'b0;
      invalid_reg <= 1'b0;
      in_reset_reg <= 1'b1;
    end else begin
      flash_reg <= dec_flash;
      download_reg <= dec_download;
      print_reg <= dec_print;
      invalid_reg <= dec_invalid;
      in_reset_reg <= sys_rst_reg;
    end
  end

  assign boot_flash = flash_reg;
  assign boot_download = download_reg;
  assign print_en = print_reg;
  assign strap_invalid = invalid_reg;
  assign sys_reset_active = in_reset_reg;

  // ****************************************
  // apb slave
  // ****************************************
  reg [`STRAP_W-1:0] pin_out_reg;
  reg [`STRAP_W-1:0] pin_oe_reg;
  reg [`DATA_W-1:0] prdata_reg;
  reg [`DATA_W-1:0] prdata_next;
  reg pready_reg;
  reg pslverr_reg;
  reg pslverr_next;
  wire setup_phase;
  wire access_done;
  wire [`DATA_W-1:0] boot_word;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;

  assign boot_word = {{(`DATA_W-`BOOT_IN_RESET_BIT-1){1'b0}}, in_reset_reg, invalid_reg, print_reg,
                      download_reg, flash_reg};

  // read data is chosen in the setup cycle, so every access ends without wait
  always @* begin
    prdata_next = `DATA_ZERO;
    pslverr_next = 1'b0;
    if (paddr == `OFS_STRAP_STATUS) begin
      prdata_next = {{(`DATA_W-`STRAP_W){1'b0}}, strap_bits};
    end else if (paddr == `OFS_BOOT_STATUS) begin
      prdata_next = boot_word;
    end else if (paddr == `OFS_PIN_OUT) begin
      prdata_next = {{(`DATA_W-`STRAP_W){1'b0}}, pin_out_reg};
    end else if (paddr == `OFS_PIN_OE) begin
      prdata_next = {{(`DATA_W-`STRAP_W){1'b0}}, pin_oe_reg};
    end else if (paddr == `OFS_PIN_IN) begin
      prdata_next = {{(`DATA_W-`STRAP_W){1'b0}}, pin_level};
    end else if (paddr == `OFS_PRINT_CTRL) begin
      prdata_next = {{(`DATA_W-2){1'b0}}, print_ctrl_fuse};
    end else begin
      pslverr_next = 1'b1;
    end
    if (pwrite) begin
      prdata_next = `DATA_ZERO;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `DATA_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg <= 1'b1;
    end else begin
      prdata_reg <= `DATA_ZERO;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // writes land only at the completing edge; read-only addresses ignore data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= `PIN_OUT_RESET;
      pin_oe_reg <= `PIN_OE_RESET;
    end else if (access_done && pwrite) begin
      if (paddr == `OFS_PIN_OUT) begin
        pin_out_reg <= pwdata[`STRAP_W-1:0];
      end else if (paddr == `OFS_PIN_OE) begin
        pin_oe_reg <= pwdata[`STRAP_W-1:0];
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  reg [`STRAP_W-1:0] drv_out_reg;
  reg [`STRAP_W-1:0] drv_oe_reg;
  reg pullup_reg;

  // during reset the pins are inputs only, so the board and the pin c pull-up set the levels
  genvar p;
  generate
    for (p = 0; p < `STRAP_W; p = p + 1) begin : g_pin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drv_out_reg[p] <= 1'b0;
          drv_oe_reg[p] <= 1'b0;
        end else begin
          drv_out_reg[p] <= pin_out_reg[p];
          // released only once the reported reset falls, never ahead of it
          drv_oe_reg[p] <= pin_oe_reg[p] & ~sys_rst_next & ~sys_rst_reg;
        end
      end
    end
  endgenerate

  // pull-up kept on unless the pin is driven by its ordinary function
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_reg <= 1'b1;
    end else begin
      pullup_reg <= sys_rst_next | sys_rst_reg | ~pin_oe_reg[`STRAP_C];
    end
  end

  assign strap_pin_a_out = drv_out_reg[`STRAP_A];
  assign strap_pin_a_oe = drv_oe_reg[`STRAP_A];
  assign strap_pin_b_out = drv_out_reg[`STRAP_B];
  assign strap_pin_b_oe = drv_oe_reg[`STRAP_B];
  assign strap_pin_c_out = drv_out_reg[`STRAP_C];
  assign strap_pin_c_oe = drv_oe_reg[`STRAP_C];
  assign strap_pin_c_pullup = pullup_reg;

endmodule

// >>> design/strap_sampler.v
// latch bank that samples the strap pins while the chip is in system reset
`timescale 1ns/1ps
`include "strap_boot_regs.vh"

module strap_sampler (
  input wire pclk,
  input wire presetn,
  input wire sample_en,
  input wire [`STRAP_W-1:0] pin_level,
  output wire [`STRAP_W-1:0] strap_bits
);

  localparam [`STRAP_W-1:0] STRAP_INIT = `STRAP_RESET;

  reg [`STRAP_W-1:0] bit_reg;

  genvar i;
  generate
    for (i = 0; i < `STRAP_W; i = i + 1) begin : g_bit
      // keeps tracking while in reset, so the value held is the level at release
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bit_reg[i] <= STRAP_INIT[i];
        end else if (sample_en) begin
          bit_reg[i] <= pin_level[i];
        end
      end
    end
  endgenerate

  assign strap_bits = bit_reg;

endmodule

// >>> sim/strap_board_model.sv
// board side of the strap pins: resistors, host outputs and wire resolution
`timescale 1ns/1ps
module strap_board_model (
  input wire logic pclk,
  input wire logic [2:0] drv_en,
  input wire logic [2:0] drv_val,
  input wire logic [2:0] dev_out,
  input wire logic [2:0] dev_oe,
  input wire logic pull_c,
  output logic [2:0] pin
);
  logic [2:0] drift = 3'h5;
  // a floating pin with no pull must not look like a steady level
  always @(posedge pclk) begin
    drift <= ~drift;
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (dev_oe[i]) pin[i] = dev_out[i];
      else if (drv_en[i]) pin[i] = drv_val[i];
      else if (i == 2 && pull_c) pin[i] = 1'h1;
      else pin[i] = drift[i];
    end
  end
endmodule

// >>> sim/strap_latch_monitor.sv
// concurrent checks on the strap latch and boot select top ports
`timescale 1ns/1ps
`include "strap_boot_regs.vh"
module strap_latch_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_en,
  input wire logic por_rst,
  input wire logic wdt_rst,
  input wire logic brownout_rst,
  input wire logic super_wdt_rst,
  input wire logic glitch_rst,
  input wire logic [1:0] print_ctrl_fuse,
  input wire logic strap_pin_a_oe,
  input wire logic strap_pin_b_oe,
  input wire logic strap_pin_c_oe,
  input wire logic strap_pin_c_pullup,
  input wire logic sys_reset_active,
  input wire logic boot_flash,
  input wire logic boot_download,
  input wire logic print_en,
  input wire logic strap_invalid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire any_src = por_rst | wdt_rst | brownout_rst | super_wdt_rst | glitch_rst | !chip_en;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  reset_enter_a: assert property (any_src |-> ##[1:2] sys_reset_active)
    else $error("reset source did not raise system reset");
  pins_idle_a: assert property (sys_reset_active && $past(sys_reset_active)
    |-> !(strap_pin_a_oe | strap_pin_b_oe | strap_pin_c_oe))
    else $error("strap pin driven during reset");
  pullup_on_a: assert property (sys_reset_active |-> strap_pin_c_pullup)
    else $error("pin c pull-up off during reset");
  straps_hold_a: assert property (!sys_reset_active && !$past(sys_reset_active)
    && !$past(sys_reset_active, 2)
    |-> $stable(boot_flash) && $stable(boot_download) && $stable(strap_invalid))
    else $error("decode changed outside reset");
  boot_excl_a: assert property (!(boot_flash && boot_download))
    else $error("flash and download both selected");
  invalid_quiet_a: assert property (strap_invalid |-> !boot_flash && !boot_download)
    else $error("boot selected on invalid straps");
  print_fixed_a: assert property ($past(presetn) && $stable(print_ctrl_fuse)
    && print_ctrl_fuse[0] == print_ctrl_fuse[1] |-> print_en == !print_ctrl_fuse[0])
    else $error("print enable ignores fixed fuse code");
  apb_answer_a: assert property (setup_s |=> answer_s)
    else $error("apb answer not a one cycle pulse");
  err_map_a: assert property (pslverr |-> pready && paddr > `OFS_PRINT_CTRL)
    else $error("error on mapped address");
  idle_data_a: assert property (!pready |-> prdata == `DATA_ZERO)
    else $error("read data outside access");
endmodule
bind strap_pin_latch_boot_select strap_latch_monitor strap_latch_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_en(chip_en),
  .por_rst(por_rst), .wdt_rst(wdt_rst), .brownout_rst(brownout_rst),
  .super_wdt_rst(super_wdt_rst), .glitch_rst(glitch_rst), .print_ctrl_fuse(print_ctrl_fuse),
  .strap_pin_a_oe(strap_pin_a_oe), .strap_pin_b_oe(strap_pin_b_oe),
  .strap_pin_c_oe(strap_pin_c_oe), .strap_pin_c_pullup(strap_pin_c_pullup),
  .sys_reset_active(sys_reset_active), .boot_flash(boot_flash),
  .boot_download(boot_download), .print_en(print_en), .strap_invalid(strap_invalid));

// >>> sim/strap_pin_latch_boot_select_tb_top.sv
// self-checking bench for the strap latch and boot select block
`timescale 1ns/1ps
`include "strap_boot_regs.vh"
module strap_pin_latch_boot_select_tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic chip_en = 1'h1, pready, pslverr, sra, fl, dl, pe, inv, pull_c;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [4:0] src = 5'h0;
  logic [1:0] fuse = 2'h0;
  logic [2:0] pin, dout, doe, drv_en = 3'h3, drv_val = 3'h3;
  logic [2:0] vals [6] = '{3'h3, 3'h5, 3'h6, 3'h7, 3'h2, 3'h4};
  int num_errors = 0, tests_run = 0;
  strap_pin_latch_boot_select #(.HOLD_CYCLES(8)) strap_pin_latch_boot_select_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_en(chip_en), .por_rst(src[0]), .wdt_rst(src[1]), .brownout_rst(src[2]),
    .super_wdt_rst(src[3]), .glitch_rst(src[4]), .print_ctrl_fuse(fuse),
    .strap_pin_a_in(pin[0]), .strap_pin_a_out(dout[0]), .strap_pin_a_oe(doe[0]),
    .strap_pin_b_in(pin[1]), .strap_pin_b_out(dout[1]), .strap_pin_b_oe(doe[1]),
    .strap_pin_c_in(pin[2]), .strap_pin_c_out(dout[2]), .strap_pin_c_oe(doe[2]),
    .strap_pin_c_pullup(pull_c), .sys_reset_active(sra), .boot_flash(fl),
    .boot_download(dl), .print_en(pe), .strap_invalid(inv));
  strap_board_model strap_board_model_i (.pclk(pclk), .drv_en(drv_en), .drv_val(drv_val),
    .dev_out(dout), .dev_oe(doe), .pull_c(pull_c), .pin(pin));
  always #50 pclk = ~pclk;
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'h0, a, 32'h0, d, e);
    chk(what, d, exp);
  endtask
  // c is left to the pull-up after the source drops whenever it should read high
  task automatic restrap(input int s, input logic [2:0] v);
    int n;
    // pin a differs while the source is up; only the level at release may be latched
    drv_val <= v ^ 3'h1;
    drv_en <= 3'h7;
    if (s < 5) src[s] <= 1'h1;
    else chip_en <= 1'h0;
    repeat (3) @(posedge pclk);
    src <= 5'h0;
    chip_en <= 1'h1;
    drv_val <= v;
    drv_en <= {~v[2], 2'h3};
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sra !== 1'h0 && n < 40);
    if (sra !== 1'h0) begin
      num_errors++;
      conclude();
    end
    @(posedge pclk);
    drv_en <= 3'h0;
  endtask
  task automatic dec_chk(input logic [2:0] v);
    logic pr;
    repeat (2) @(posedge pclk);
    chk("flash", fl, v[0] & v[2]);
    chk("download", dl, v[0] & v[1] & ~v[2]);
    chk("invalid", inv, 1'h0);
    rd_chk("strap status", `OFS_STRAP_STATUS, {29'h0, v});
    for (int f = 0; f < 4; f++) begin
      fuse <= f[1:0];
      repeat (2) @(posedge pclk);
      pr = (f == 0) | (f == 1 & ~v[1]) | (f == 2 & v[1]);
      chk("print", pe, pr);
    end
    rd_chk("fuse", `OFS_PRINT_CTRL, 32'h3);
    rd_chk("boot status", `OFS_BOOT_STATUS, {30'h0, v[0] & v[1] & ~v[2], v[0] & v[2]});
  endtask
  task automatic handback();
    logic [31:0] d;
    logic e;
    rd_chk("pin oe reset", `OFS_PIN_OE, 32'h0);
    apb(1'h1, `OFS_PIN_OUT, 32'h5, d, e);
    apb(1'h1, `OFS_PIN_OE, 32'h7, d, e);
    apb(1'h1, `OFS_STRAP_STATUS, 32'h0, d, e);
    chk("ro write err", e, 1'h0);
    chk("pin oe", doe, 3'h7);
    chk("pin out", dout, 3'h5);
    rd_chk("pin in", `OFS_PIN_IN, 32'h5);
    rd_chk("strap kept", `OFS_STRAP_STATUS, 32'h7);
    apb(1'h0, 12'h018, 32'h0, d, e);
    chk("unmapped err", e, 1'h1);
    chk("unmapped data", d, 32'h0);
    // pin c driven by its ordinary function, so the pull-up is off
    chk("pullup off", pull_c, 1'h0);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    restrap(0, 3'h7);
    dec_chk(3'h7);
    handback();
    for (int i = 0; i < 6; i++) begin
      restrap(i, vals[i]);
      dec_chk(vals[i]);
    end
    chk("oe after reset", doe, 3'h7);
    conclude();
  end
endmodule
